/* File: logic/lcd_command_decoder.sv */
/*
 Command decoder of a graphic display controller: takes host bytes with a
 command/data select and keeps the control state and RAM address pointers.
 Assumes one host byte per cycle at most, synchronous to SYS_CLK, and that
 the host waits for BUSY_FLAG low before a new command.
*/
// Overview of operation
// R1: Byte 1011xxxx loads the row bank index, legal values 0 to 8.
// R2: Banks 0-7 map eight common lines each; bank 8 drives the icon row.
// R3: Byte 00100xxx loads supply control bits from byte bits [2:0]; reset value 100b.
// R4: Byte 81h then next control byte loads six-bit contrast volume; reset 32.
// R5: All-on flag forces every segment output on; RAM untouched; reset 0.
// R6: Invert flag outputs inverse of RAM data on segments.
// R7: Display enable 1 runs wake, power restore, then driver enable.
// R8: Horizontal flip reverses column mapping immediately; resets to 0.
// R9: Byte 1100xxxx stores bit 3 as vertical flip.
// R10: Byte E2h returns every control register to its default.
// R11: Bias select picks panel bias ratio; resets to 0.
// R12: Byte E0h sets cursor mode and saves the column pointer.
// R13: In cursor mode writes increment column without wrap.
// R14: In cursor mode reads leave the column pointer unchanged.
// R15: Byte EEh clears cursor mode and restores the saved column.
// R16: Byte FAh then next byte loads slope bit 7 and wrap bits 1:0.
// R17: Slope select 0 gives -0.05 percent per degree, 1 gives -0.11.
// R18: Wrap bit 0 enables row bank wrap, bit 1 column wrap.
// R19: Select 0 means control byte, 1 data; read-not-write 1 means read.
// R20: Host issues commands only while busy flag reads 0.
// R21: RAM accesses address row bank index with column pointer 0 to 131; here cursor mode writes can step the column past 131.
// R22: Column wraps to 0 after 131 if wrap bit 1 is set, else holds at 131; row advances and wraps after 8 if bit 0 is set.
// R23: System reset restores vertical flip 0 and advanced byte 90h.
`timescale 1ns/1ps
module lcd_command_decoder #(
    parameter int COL_W  = 8,
    parameter int BANK_W = 4
) (
    input  wire logic              SYS_CLK,
    input  wire logic              SYS_RST,
    input  wire logic              BYTE_VALID,
    input  wire logic              CMD_DATA_SEL,
    input  wire logic              READ_NOT_WRITE,
    input  wire logic [7:0]        HOST_BYTE,
    input  wire logic [7:0]        RAM_RDATA,
    output logic      [BANK_W-1:0] ROW_BANK_INDEX,
    output logic      [COL_W-1:0]  COLUMN_POINTER,
    output logic                   RAM_WRITE,
    output logic                   RAM_READ,
    output logic      [7:0]        RAM_WDATA,
    output logic      [7:0]        SEG_DATA,
    output logic                   ICON_ROW_OUTPUT,
    output logic      [2:0]        SUPPLY_CTRL_BITS,
    output logic      [5:0]        CONTRAST_VOLUME,
    output logic      [2:0]        PANEL_OUTPUT_FLAGS,
    output logic                   HORIZONTAL_FLIP,
    output logic                   VERTICAL_FLIP,
    output logic                   BIAS_SELECT,
    output logic                   CURSOR_MODE_FLAG,
    output logic      [COL_W-1:0]  SAVED_COLUMN,
    output logic      [7:0]        ADVANCED_CTRL_BYTE,
    output logic                   TEMP_SLOPE_SELECT,
    output logic      [1:0]        WRAP_ENABLES,
    output logic                   SLEEP_EXIT,
    output logic                   POWER_RESTORE,
    output logic                   DRIVERS_ENABLE,
    output logic                   BUSY_FLAG
);
    import lcd_cmd_pkg::*;

    // ------------------------------------------------------------
    // Byte classification
    // ------------------------------------------------------------
    seq_state_t  seq_reg;
    seq_state_t  seq_next;
    pwr_state_t  pwr_reg;
    pwr_state_t  pwr_next;
    logic [BANK_W-1:0] bank_reg;
    logic [COL_W-1:0]  col_reg;
    logic [COL_W-1:0]  saved_reg;
    logic [2:0]  ratio_reg;
    logic [5:0]  volume_reg;
    logic [2:0]  flags_reg;
    logic        hflip_reg;
    logic        vflip_reg;
    logic        bias_reg;
    logic        cursor_reg;
    logic [7:0]  adv_reg;
    logic [7:0]  seg_reg;
    logic [7:0]  wdata_reg;

    wire ctl_wr   = BYTE_VALID && !CMD_DATA_SEL && !READ_NOT_WRITE;              // R19
    wire dat_wr   = BYTE_VALID && CMD_DATA_SEL && !READ_NOT_WRITE;               // R19
    wire dat_rd   = BYTE_VALID && CMD_DATA_SEL && READ_NOT_WRITE;                // R19
    wire plain    = ctl_wr && (seq_reg == ST_IDLE);
    wire vol_arg  = ctl_wr && (seq_reg == ST_VOLUME);
    wire adv_arg  = ctl_wr && (seq_reg == ST_ADV);
    wire is_page  = plain && HOST_BYTE[7:4] == NIB_PAGE;
    wire is_ratio = plain && HOST_BYTE[7:3] == PFX_RATIO;
    wire is_allon = plain && HOST_BYTE[7:1] == PFX_ALL_ON;
    wire is_inv   = plain && HOST_BYTE[7:1] == PFX_INVERT;
    wire is_en    = plain && HOST_BYTE[7:1] == PFX_ENABLE;
    wire is_hflip = plain && HOST_BYTE[7:1] == PFX_HFLIP;
    wire is_vflip = plain && HOST_BYTE[7:4] == NIB_VFLIP;
    wire is_bias  = plain && HOST_BYTE[7:1] == PFX_BIAS;
    wire is_rst   = SYS_RST || (plain && HOST_BYTE == OP_SYS_RESET);                // R10
    wire is_cset  = plain && HOST_BYTE == OP_CURSOR_SET;
    wire is_cclr  = plain && HOST_BYTE == OP_CURSOR_CLR;

    // ------------------------------------------------------------
    // Pointer advance after a data access
    // ------------------------------------------------------------
    wire col_end  = col_reg >= COL_W'(COL_LAST);
    wire wrap_col = adv_reg[BIT_WRAP_COL] && !cursor_reg;                           // R13
    wire wrap_row = adv_reg[BIT_WRAP_ROW];                                           // R18
    wire step_col = dat_wr || (dat_rd && !cursor_reg);                               // R14

    logic [COL_W-1:0]  col_next;
    logic [BANK_W-1:0] bank_next;
    always_comb begin
        col_next  = col_reg;
        bank_next = bank_reg;
        if (is_page) begin
            bank_next = HOST_BYTE[BANK_W-1:0];                                       // R1
        end else if (is_cclr) begin
            col_next = saved_reg;                                                    // R15
        end else if (step_col) begin
            if (col_end && wrap_col) begin
                col_next = '0;                                                       // R22
                if (wrap_row) begin
                    bank_next = (bank_reg >= BANK_W'(BANK_LAST)) ? '0 : bank_reg + 1'b1;
                end
            end else if (!col_end || cursor_reg) begin
                col_next = col_reg + 1'b1;                                           // R13
            end
        end
    end

    // ------------------------------------------------------------
    // Two-byte command sequencing
    // ------------------------------------------------------------
    always_comb begin
        seq_next = seq_reg;
        if (is_rst) begin
            seq_next = ST_IDLE;
        end else if (plain && HOST_BYTE == OP_VOLUME) begin
            seq_next = ST_VOLUME;                                                    // R4
        end else if (plain && HOST_BYTE == OP_ADV_CTRL) begin
            seq_next = ST_ADV;                                                       // R16
        end else if (vol_arg || adv_arg) begin
            seq_next = ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Display enable power-up order
    // ------------------------------------------------------------
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_SLEEP: if (flags_reg[BIT_ENABLE]) pwr_next = PWR_WAKE;               // R7
            PWR_WAKE:  pwr_next = PWR_POWER;                                         // R7
            PWR_POWER: pwr_next = PWR_ON;                                            // R7
            PWR_ON:    if (!flags_reg[BIT_ENABLE]) pwr_next = PWR_SLEEP;
        endcase
        if (is_rst) begin
            pwr_next = PWR_SLEEP;
        end
    end

    // ------------------------------------------------------------
    // Segment output from RAM data
    // ------------------------------------------------------------
    wire [7:0] seg_next = flags_reg[BIT_ALL_ON] ? 8'hff :                            // R5
                          (flags_reg[BIT_INVERT] ? ~RAM_RDATA : RAM_RDATA);          // R6

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        seq_reg   <= seq_next;
        pwr_reg   <= pwr_next;
        seg_reg   <= SYS_RST ? 8'h00 : seg_next;
        wdata_reg <= SYS_RST ? 8'h00 : (dat_wr ? HOST_BYTE : wdata_reg);
        if (SYS_RST) begin
            col_reg  <= '0;
            bank_reg <= '0;
        end else begin
            col_reg  <= col_next;                                                    // R21
            bank_reg <= bank_next;                                                   // R21
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (is_rst) begin                                                            // R10
            ratio_reg  <= RATIO_RST;                                                 // R3
            volume_reg <= VOLUME_RST;                                                // R4
            flags_reg  <= '0;
            hflip_reg  <= 1'b0;                                                      // R8
            vflip_reg  <= 1'b0;                                                      // R23
            bias_reg   <= 1'b0;                                                      // R11
            cursor_reg <= 1'b0;
            saved_reg  <= '0;
            adv_reg    <= ADV_CTRL_RST;                                              // R23
        end else begin
            if (is_ratio) ratio_reg <= HOST_BYTE[2:0];                               // R3
            if (vol_arg) volume_reg <= HOST_BYTE[5:0];                               // R4
            if (is_allon) flags_reg[BIT_ALL_ON] <= HOST_BYTE[0];                     // R5
            if (is_inv) flags_reg[BIT_INVERT] <= HOST_BYTE[0];                       // R6
            if (is_en) flags_reg[BIT_ENABLE] <= HOST_BYTE[0];                        // R7
            if (is_hflip) hflip_reg <= HOST_BYTE[0];                                 // R8
            if (is_vflip) vflip_reg <= HOST_BYTE[BIT_VFLIP];                         // R9
            if (is_bias) bias_reg <= HOST_BYTE[0];                                   // R11
            if (is_cset) begin
                cursor_reg <= 1'b1;                                                  // R12
                saved_reg  <= col_reg;                                               // R12
            end
            if (is_cclr) cursor_reg <= 1'b0;                                         // R15
            if (adv_arg) adv_reg <= HOST_BYTE;                                       // R16
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ROW_BANK_INDEX     = bank_reg;
    assign COLUMN_POINTER     = col_reg;
    assign RAM_WRITE          = dat_wr;
    assign RAM_READ           = dat_rd;
    assign RAM_WDATA          = wdata_reg;
    assign SEG_DATA           = seg_reg;
    assign ICON_ROW_OUTPUT    = bank_reg == BANK_W'(BANK_LAST);                      // R2
    assign SUPPLY_CTRL_BITS   = ratio_reg;
    assign CONTRAST_VOLUME    = volume_reg;
    assign PANEL_OUTPUT_FLAGS = flags_reg;
    assign HORIZONTAL_FLIP    = hflip_reg;
    assign VERTICAL_FLIP      = vflip_reg;
    assign BIAS_SELECT        = bias_reg;
    assign CURSOR_MODE_FLAG   = cursor_reg;
    assign SAVED_COLUMN       = saved_reg;
    assign ADVANCED_CTRL_BYTE = adv_reg;
    assign TEMP_SLOPE_SELECT  = adv_reg[BIT_TSLOPE];                                 // R17
    assign WRAP_ENABLES       = adv_reg[1:0];                                        // R18
    assign SLEEP_EXIT         = pwr_reg != PWR_SLEEP;                                // R7
    assign POWER_RESTORE      = pwr_reg == PWR_POWER || pwr_reg == PWR_ON;           // R7
    assign DRIVERS_ENABLE     = pwr_reg == PWR_ON;                                   // R7
    assign BUSY_FLAG          = pwr_reg == PWR_WAKE || pwr_reg == PWR_POWER;         // R20
endmodule

/* File: pkg/lcd_cmd_pkg.sv */
/*
 Constants for the display command decoder: opcodes, field positions,
 reset values and limits.
 Assumes nothing of its surroundings.
*/
package lcd_cmd_pkg;
    localparam logic [7:0] OP_VOLUME     = 8'h81;
    localparam logic [7:0] OP_SYS_RESET  = 8'he2;
    localparam logic [7:0] OP_CURSOR_SET = 8'he0;
    localparam logic [7:0] OP_CURSOR_CLR = 8'hee;
    localparam logic [7:0] OP_ADV_CTRL   = 8'hfa;
    localparam logic [3:0] NIB_PAGE      = 4'hb;
    localparam logic [3:0] NIB_VFLIP     = 4'hc;
    localparam logic [4:0] PFX_RATIO     = 5'h04;
    localparam logic [6:0] PFX_ALL_ON    = 7'h52;
    localparam logic [6:0] PFX_INVERT    = 7'h53;
    localparam logic [6:0] PFX_ENABLE    = 7'h57;
    localparam logic [6:0] PFX_HFLIP     = 7'h50;
    localparam logic [6:0] PFX_BIAS      = 7'h51;
    localparam logic [2:0] RATIO_RST     = 3'h4;
    localparam logic [5:0] VOLUME_RST    = 6'h20;
    localparam logic [7:0] ADV_CTRL_RST  = 8'h90;
    localparam logic [7:0] COL_LAST      = 8'h83;
    localparam logic [3:0] BANK_LAST     = 4'h8;
    localparam int         BIT_ALL_ON    = 1;
    localparam int         BIT_INVERT    = 0;
    localparam int         BIT_ENABLE    = 2;
    localparam int         BIT_VFLIP     = 3;
    localparam int         BIT_TSLOPE    = 7;
    localparam int         BIT_WRAP_ROW  = 0;
    localparam int         BIT_WRAP_COL  = 1;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_VOLUME = 2'b01,
        ST_ADV    = 2'b10
    } seq_state_t;
    typedef enum logic [1:0] {
        PWR_SLEEP = 2'b00,
        PWR_WAKE  = 2'b01,
        PWR_POWER = 2'b10,
        PWR_ON    = 2'b11
    } pwr_state_t;
endpackage

/* File: tb/lcd_command_decoder_asserts.sv */
/*
 Concurrent checks on the command decoder ports.
 Assumes binding to lcd_command_decoder and one host byte per cycle at most.
*/
`timescale 1ns/1ps
module lcd_command_decoder_asserts
    import lcd_cmd_pkg::*;
#(
    parameter int COL_W  = 8,
    parameter int BANK_W = 4
) (
    input wire logic              SYS_CLK,
    input wire logic              SYS_RST,
    input wire logic              BYTE_VALID,
    input wire logic              CMD_DATA_SEL,
    input wire logic              READ_NOT_WRITE,
    input wire logic [7:0]        HOST_BYTE,
    input wire logic [7:0]        RAM_RDATA,
    input wire logic [BANK_W-1:0] ROW_BANK_INDEX,
    input wire logic [COL_W-1:0]  COLUMN_POINTER,
    input wire logic              RAM_WRITE,
    input wire logic              RAM_READ,
    input wire logic [7:0]        SEG_DATA,
    input wire logic              ICON_ROW_OUTPUT,
    input wire logic [2:0]        SUPPLY_CTRL_BITS,
    input wire logic [5:0]        CONTRAST_VOLUME,
    input wire logic [2:0]        PANEL_OUTPUT_FLAGS,
    input wire logic              CURSOR_MODE_FLAG,
    input wire logic [COL_W-1:0]  SAVED_COLUMN,
    input wire logic [7:0]        ADVANCED_CTRL_BYTE,
    input wire logic [1:0]        WRAP_ENABLES,
    input wire logic              SLEEP_EXIT,
    input wire logic              POWER_RESTORE,
    input wire logic              DRIVERS_ENABLE,
    input wire logic              BUSY_FLAG
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    logic pend_vol;
    logic pend_adv;
    wire  wr_ctl = BYTE_VALID && !CMD_DATA_SEL && !READ_NOT_WRITE;
    wire  cmd    = wr_ctl && !pend_vol && !pend_adv;
    wire  dat_wr = BYTE_VALID && CMD_DATA_SEL && !READ_NOT_WRITE;
    wire  dat_rd = BYTE_VALID && CMD_DATA_SEL && READ_NOT_WRITE;
    // Tracks whether the next control byte is an argument byte
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pend_vol <= 1'b0;
            pend_adv <= 1'b0;
        end else if (wr_ctl) begin
            pend_vol <= cmd && HOST_BYTE == OP_VOLUME;
            pend_adv <= cmd && HOST_BYTE == OP_ADV_CTRL;
        end
    end
    a_page_load: assert property (cmd && HOST_BYTE[7:4] == NIB_PAGE |=>
        ROW_BANK_INDEX == $past(HOST_BYTE[3:0])) else $error("page index not loaded");
    a_icon_row: assert property (ICON_ROW_OUTPUT == (ROW_BANK_INDEX == BANK_LAST))
        else $error("icon row decode wrong");
    a_volume_arg: assert property (pend_vol && wr_ctl |=>
        CONTRAST_VOLUME == $past(HOST_BYTE[5:0])) else $error("volume not loaded");
    a_seg_output: assert property (!$past(SYS_RST) |-> SEG_DATA ==
        ($past(PANEL_OUTPUT_FLAGS[1]) ? 8'hff : $past(PANEL_OUTPUT_FLAGS[0]) ?
        ~$past(RAM_RDATA) : $past(RAM_RDATA))) else $error("segment data wrong");
    a_enable_seq: assert property (cmd && HOST_BYTE == 8'haf && !PANEL_OUTPUT_FLAGS[2]
        |=> PANEL_OUTPUT_FLAGS[2] ##1 SLEEP_EXIT ##1 POWER_RESTORE
        ##1 DRIVERS_ENABLE && !BUSY_FLAG) else $error("enable sequence wrong");
    a_sys_reset: assert property (cmd && HOST_BYTE == OP_SYS_RESET |=>
        SUPPLY_CTRL_BITS == RATIO_RST && CONTRAST_VOLUME == VOLUME_RST
        && PANEL_OUTPUT_FLAGS == 3'h0 && ADVANCED_CTRL_BYTE == ADV_CTRL_RST)
        else $error("defaults not restored");
    a_cursor_save: assert property (cmd && HOST_BYTE == OP_CURSOR_SET |=>
        CURSOR_MODE_FLAG && SAVED_COLUMN == $past(COLUMN_POINTER))
        else $error("cursor save wrong");
    a_cursor_write: assert property (CURSOR_MODE_FLAG && dat_wr |=>
        COLUMN_POINTER == $past(COLUMN_POINTER) + 1'b1) else $error("cursor write step");
    a_cursor_read: assert property (CURSOR_MODE_FLAG && dat_rd |=>
        $stable(COLUMN_POINTER)) else $error("cursor read moved column");
    a_cursor_clear: assert property (cmd && HOST_BYTE == OP_CURSOR_CLR |=>
        !CURSOR_MODE_FLAG && COLUMN_POINTER == $past(SAVED_COLUMN))
        else $error("cursor restore wrong");
    a_adv_arg: assert property (pend_adv && wr_ctl |=>
        ADVANCED_CTRL_BYTE == $past(HOST_BYTE)) else $error("advanced byte wrong");
    a_col_wrap: assert property (!CURSOR_MODE_FLAG && dat_wr && WRAP_ENABLES[1]
        && COLUMN_POINTER == COL_LAST |=> COLUMN_POINTER == 0) else $error("no wrap");
    a_ram_strobes: assert property (RAM_WRITE == dat_wr && RAM_READ == dat_rd)
        else $error("RAM strobe decode wrong");
    c_cursor: cover property (cmd && HOST_BYTE == OP_CURSOR_SET);
    c_volume: cover property (pend_vol && wr_ctl);
    c_wrap: cover property (dat_wr && COLUMN_POINTER == COL_LAST);
endmodule
bind lcd_command_decoder lcd_command_decoder_asserts #(.COL_W(COL_W), .BANK_W(BANK_W)) chk_u (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .BYTE_VALID(BYTE_VALID),
    .CMD_DATA_SEL(CMD_DATA_SEL), .READ_NOT_WRITE(READ_NOT_WRITE), .HOST_BYTE(HOST_BYTE),
    .RAM_RDATA(RAM_RDATA), .ROW_BANK_INDEX(ROW_BANK_INDEX), .SEG_DATA(SEG_DATA),
    .COLUMN_POINTER(COLUMN_POINTER), .ICON_ROW_OUTPUT(ICON_ROW_OUTPUT),
    .RAM_WRITE(RAM_WRITE), .RAM_READ(RAM_READ),
    .SUPPLY_CTRL_BITS(SUPPLY_CTRL_BITS), .CONTRAST_VOLUME(CONTRAST_VOLUME),
    .PANEL_OUTPUT_FLAGS(PANEL_OUTPUT_FLAGS), .CURSOR_MODE_FLAG(CURSOR_MODE_FLAG),
    .SAVED_COLUMN(SAVED_COLUMN), .ADVANCED_CTRL_BYTE(ADVANCED_CTRL_BYTE),
    .WRAP_ENABLES(WRAP_ENABLES), .SLEEP_EXIT(SLEEP_EXIT), .POWER_RESTORE(POWER_RESTORE),
    .DRIVERS_ENABLE(DRIVERS_ENABLE), .BUSY_FLAG(BUSY_FLAG));

/* File: tb/lcd_host_model.sv */
/*
 Host side of the parallel port: sends one byte per call.
 Assumes the decoder takes a byte on the rising clock edge.
*/
`timescale 1ns/1ps
module lcd_host_model (
    input  wire logic       clk,
    input  wire logic       busy,
    output logic            valid,
    output logic            sel,
    output logic            rnw,
    output logic [7:0]      data
);
    initial begin
        valid = 1'b0;
        sel   = 1'b0;
        rnw   = 1'b0;
        data  = 8'h00;
    end
    // Released byte lines show the inverse of the last byte
    task automatic put(input logic s, input logic r, input logic [7:0] b);
        @(posedge clk);
        #1;
        while (busy) begin
            @(posedge clk);
            #1;
        end
        valid <= 1'b1;
        sel   <= s;
        rnw   <= r;
        data  <= b;
        @(posedge clk);
        valid <= 1'b0;
        data  <= ~b;
        #1;
    endtask
endmodule

/* File: tb/lcd_command_decoder_tb.sv */
/*
 Self-checking bench for the command decoder.
 Assumes the host model and the checker files are compiled before it.
*/
`timescale 1ns/1ps
module lcd_command_decoder_tb;
    import lcd_cmd_pkg::*;
    logic clk, rst;
    logic [7:0] rdata;
    int num_errors, checked, cycles;
    wire valid, sel, rnw, icon, hflip, vflip, bias, cur, ts, slp, pwr, drv, busy;
    wire [7:0] hbyte, col, saved, wdat, seg, adv;
    wire [3:0] bank;
    wire [2:0] sup, flags;
    wire [5:0] vol;
    wire [1:0] wrap;
    lcd_host_model host_u (.clk(clk), .busy(busy), .valid(valid), .sel(sel), .rnw(rnw),
        .data(hbyte));
    lcd_command_decoder dut_u (.SYS_CLK(clk), .SYS_RST(rst), .BYTE_VALID(valid),
        .CMD_DATA_SEL(sel), .READ_NOT_WRITE(rnw), .HOST_BYTE(hbyte), .RAM_RDATA(rdata),
        .ROW_BANK_INDEX(bank), .COLUMN_POINTER(col), .RAM_WRITE(), .RAM_READ(),
        .RAM_WDATA(wdat), .SEG_DATA(seg), .ICON_ROW_OUTPUT(icon), .SUPPLY_CTRL_BITS(sup),
        .CONTRAST_VOLUME(vol), .PANEL_OUTPUT_FLAGS(flags), .HORIZONTAL_FLIP(hflip),
        .VERTICAL_FLIP(vflip), .BIAS_SELECT(bias), .CURSOR_MODE_FLAG(cur),
        .SAVED_COLUMN(saved), .ADVANCED_CTRL_BYTE(adv), .TEMP_SLOPE_SELECT(ts),
        .WRAP_ENABLES(wrap), .SLEEP_EXIT(slp), .POWER_RESTORE(pwr), .DRIVERS_ENABLE(drv),
        .BUSY_FLAG(busy));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cw(input logic [7:0] b); host_u.put(1'b0, 1'b0, b); endtask
    task automatic dw(input logic [7:0] b); host_u.put(1'b1, 1'b0, b); endtask
    task automatic step; @(posedge clk); #1; endtask
    task automatic t_defaults;
        chk("ratio", sup, 8'h04);
        chk("volume", vol, 8'h20);
        chk("flags", {hflip, vflip, bias, flags}, 8'h00);
        chk("adv", {ts, adv[6:2], wrap}, 8'h90);
    endtask
    task automatic t_control;
        cw(8'h27); chk("ratio", sup, 8'h07);
        cw(OP_VOLUME); dw(8'h55); cw(8'hff); chk("volume", vol, 8'h3f);
        cw(8'ha3); cw(8'ha1); cw(8'hc8); chk("dir", {bias, hflip, vflip}, 8'h07);
        cw(OP_ADV_CTRL); cw(8'h11); chk("adv", {ts, adv[6:2], wrap}, 8'h11);
        rdata <= 8'h3c;
        cw(8'ha5); cw(8'ha7); step(); chk("seg on", seg, 8'hff);
        cw(8'ha4); step(); chk("seg inv", seg, 8'hc3);
        cw(8'ha6); step(); chk("seg", seg, 8'h3c);
        cw(8'haf); chk("enable", flags, 8'h04);
        step(); chk("wake", {slp, busy}, 8'h03);
        step(); chk("power", pwr, 8'h01);
        step(); chk("drivers", {drv, busy}, 8'h02);
        cw(OP_SYS_RESET); t_defaults(); chk("vflip", vflip, 8'h00);
    endtask
    task automatic t_pages;
        for (int i = 0; i <= 8; i++) begin
            cw({NIB_PAGE, i[3:0]}); chk("bank", {icon, 3'h0, bank}, {i == 8, 3'h0, i[3:0]});
        end
    endtask
    task automatic t_walk;
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        repeat (140) dw(8'h5a);
        chk("col hold", col, COL_LAST);
        cw(OP_ADV_CTRL); cw(8'h93); cw(8'hb8); dw(8'ha6);
        chk("col wrap", {bank, col[3:0]}, 8'h00); chk("wdata", wdat, 8'ha6);
        repeat (131) dw(8'h01);
        cw(OP_CURSOR_SET); chk("save", {cur, saved[6:0]}, 8'h83);
        dw(8'h02); chk("cur wr", col, 8'h84);
        host_u.put(1'b1, 1'b1, 8'h00); chk("cur rd", col, 8'h84);
        cw(OP_CURSOR_CLR); chk("restore", {cur, col[6:0]}, 8'h03);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        rdata = 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        step();
        t_defaults();
        t_control();
        t_pages();
        t_walk();
        test_done();
    end
endmodule
